// File: common/apm_pkg.sv
// Package for the converter power-state controller and its host.
// Assumes a single 40 MHz core clock shared by both ends.
package apm_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  // Least nap-exit high time on the start input
  localparam int unsigned NAP_EXIT_HIGH_NS = 200;
  localparam int unsigned NAP_EXIT_CYCLES = (NAP_EXIT_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  // Longest conversion time, rounded down
  localparam int unsigned CONV_TIME_NS = 310;
  localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
  // Recovery wait after shutdown with an external reference
  localparam int unsigned RECOVERY_MS = 5;
  // Scaled to nanoseconds first so the product stays within 32 bits
  localparam int unsigned RECOVERY_CYCLES = (RECOVERY_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  // Supply threshold, in millivolts
  localparam logic [15:0] SUPPLY_MIN_MV = 16'h09c4;
  localparam int unsigned SUPPLY_MV_W = 16;
  localparam int unsigned RESULT_W = 16;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int unsigned CNT_W = 20;

  typedef enum logic [2:0] {
    APM_POR = 3'b000,
    APM_IDLE = 3'b001,
    APM_CONV = 3'b011,
    APM_NAP = 3'b010,
    APM_SHUT = 3'b110
  } apm_state_e;

  typedef enum logic [2:0] {
    APH_WAIT = 3'b000,
    APH_HIGH = 3'b001,
    APH_LOW = 3'b011,
    APH_BUSY = 3'b010,
    APH_SHUT = 3'b110,
    APH_RECOVER = 3'b111
  } aph_state_e;
endpackage

// File: common/apm_if.sv
// Pin-level link between converter and host.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface apm_if;
  logic conversion_start_n;
  logic power_down_request;
  logic busy;
  logic [apm_pkg::RESULT_W-1:0] result;
  modport device (
    input conversion_start_n,
    input power_down_request,
    output busy,
    output result
  );
  modport host (
    output conversion_start_n,
    output power_down_request,
    input busy,
    input result
  );
endinterface

// File: design/apm_device.sv
// Converter end: power-on reset, conversion timing, nap and shutdown.
// Assumes link pins come from another domain and are synchronised here.
`timescale 1ns/1ps
// Contract
// (R1) Reset converter at power-up and below 2.5 V
// (R2) First conversion after reset is valid
// (R3) Nap after conversion while start held low
// (R4) Host holds start high 200ns leaving nap
// (R5) Shutdown held ignores all conversion requests
// (R6) Shutdown turns off all functions and reference
// (R7) Shutdown request during conversion waits for completion
// (R8) Host reads shutdown-interrupted result after shutdown ends
// (R9) Host reads pending result before shutdown; this host reads it only after shutdown ends
// (R10) Falling start edge begins unrestartable busy conversion
// (R11) Low power-down input ends shutdown, powers up
// (R12) Host waits 5 ms after shutdown release
// (R13) Busy low during nap and shutdown
module apm_device #(
  parameter int unsigned CONV_CYCLES = apm_pkg::CONV_CYCLES,
  parameter int unsigned NAP_EXIT_CYCLES = apm_pkg::NAP_EXIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [apm_pkg::SUPPLY_MV_W-1:0] supply_mv,
  input wire logic [apm_pkg::RESULT_W-1:0] sample_in,
  apm_if.device link,
  output logic reference_on,
  output logic napping,
  output logic shutdown
);
  apm_pkg::apm_state_e state_reg, state_next;
  logic [2:0] start_sync_reg, pd_sync_reg;
  logic start_reg, pd_reg;
  logic [apm_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [apm_pkg::RESULT_W-1:0] result_reg;
  logic [apm_pkg::RESULT_W-1:0] sample_reg;
  logic busy_reg;

  // Three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (reset) begin
      // Host parks start low, so reset to low avoids a false falling edge
      start_sync_reg <= 3'h0;
      pd_sync_reg <= 3'h0;
      start_reg <= 1'b0;
      pd_reg <= 1'b0;
    end else begin
      start_sync_reg <= {start_sync_reg[1:0], link.conversion_start_n};
      pd_sync_reg <= {pd_sync_reg[1:0], link.power_down_request};
      if (start_sync_reg[1] == start_sync_reg[2]) begin
        start_reg <= start_sync_reg[2];
      end
      if (pd_sync_reg[1] == pd_sync_reg[2]) begin
        pd_reg <= pd_sync_reg[2];
      end
    end
  end

  wire start_fall = start_reg && (start_sync_reg[1] == start_sync_reg[2]) && !start_sync_reg[2];
  // (R1) Supply monitor holds converter in reset
  wire supply_low = supply_mv < apm_pkg::SUPPLY_MIN_MV;
  wire conv_done = (cnt_reg == apm_pkg::CNT_W'(CONV_CYCLES - 1));
  wire high_long = (cnt_reg >= apm_pkg::CNT_W'(NAP_EXIT_CYCLES));

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      apm_pkg::APM_POR: begin
        // (R2) Straight to ready, first conversion valid
        state_next = apm_pkg::APM_IDLE;
        cnt_next = '0;
      end
      apm_pkg::APM_IDLE: begin
        // (R5) Shutdown wins over a start edge
        if (pd_reg) begin
          state_next = apm_pkg::APM_SHUT;
        end else if (start_fall) begin
          // (R10) Falling edge starts conversion
          state_next = apm_pkg::APM_CONV;
          cnt_next = '0;
        end
      end
      apm_pkg::APM_CONV: begin
        // (R10) No restart; (R7) shutdown waits for completion
        cnt_next = cnt_reg + 1'b1;
        if (conv_done) begin
          cnt_next = '0;
          if (pd_reg) begin
            state_next = apm_pkg::APM_SHUT;
          end else if (!start_reg) begin
            // (R3) Start still low, enter nap
            state_next = apm_pkg::APM_NAP;
          end else begin
            state_next = apm_pkg::APM_IDLE;
          end
        end
      end
      apm_pkg::APM_NAP: begin
        // (R4) Leaving nap needs start high long enough
        if (pd_reg) begin
          state_next = apm_pkg::APM_SHUT;
        end else if (start_reg) begin
          cnt_next = high_long ? cnt_reg : cnt_reg + 1'b1;
        end else if (high_long) begin
          state_next = apm_pkg::APM_CONV;
          cnt_next = '0;
        end else begin
          cnt_next = '0;
        end
      end
      apm_pkg::APM_SHUT: begin
        // (R11) Low power-down ends shutdown
        cnt_next = '0;
        if (!pd_reg) begin
          state_next = start_reg ? apm_pkg::APM_IDLE : apm_pkg::APM_NAP;
        end
      end
      default: begin
        state_next = apm_pkg::APM_POR;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset || supply_low) begin
      state_reg <= apm_pkg::APM_POR;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Sample taken at conversion start; result held through shutdown for later read
  always_ff @(posedge core_clk) begin
    if (reset || supply_low) begin
      sample_reg <= apm_pkg::RESULT_RESET;
      result_reg <= apm_pkg::RESULT_RESET;
      busy_reg <= 1'b0;
    end else begin
      if (state_next == apm_pkg::APM_CONV && state_reg != apm_pkg::APM_CONV) begin
        sample_reg <= sample_in;
      end
      if (state_reg == apm_pkg::APM_CONV && conv_done) begin
        result_reg <= sample_reg;
      end
      // (R13) Busy only in conversion
      busy_reg <= (state_next == apm_pkg::APM_CONV);
    end
  end

  assign link.busy = busy_reg;
  assign link.result = result_reg;
  // (R6) Reference and functions off in shutdown
  assign reference_on = (state_reg != apm_pkg::APM_SHUT) && (state_reg != apm_pkg::APM_POR);
  assign napping = (state_reg == apm_pkg::APM_NAP);
  assign shutdown = (state_reg == apm_pkg::APM_SHUT);
endmodule

// File: design/apm_host.sv
// Host end: drives start and power-down pins, reads results.
// Assumes busy and result arrive from the converter's domain.
`timescale 1ns/1ps
module apm_host #(
  parameter int unsigned NAP_EXIT_CYCLES = apm_pkg::NAP_EXIT_CYCLES,
  parameter int unsigned RECOVERY_CYCLES = apm_pkg::RECOVERY_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic convert_req,
  input wire logic shutdown_req,
  output logic convert_ready,
  output logic [apm_pkg::RESULT_W-1:0] sample_data,
  output logic sample_valid,
  output logic in_shutdown,
  apm_if.host link
);
  apm_pkg::aph_state_e state_reg, state_next;
  logic [apm_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0] busy_sync_reg;
  logic busy_reg;
  logic start_n_reg, pd_reg;
  logic [apm_pkg::RESULT_W-1:0] data_reg;
  logic valid_reg;
  logic pending_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_sync_reg <= 3'h0;
      busy_reg <= 1'b0;
    end else begin
      busy_sync_reg <= {busy_sync_reg[1:0], link.busy};
      if (busy_sync_reg[1] == busy_sync_reg[2]) begin
        busy_reg <= busy_sync_reg[2];
      end
    end
  end

  wire high_done = (cnt_reg >= apm_pkg::CNT_W'(NAP_EXIT_CYCLES + 1));
  wire rec_done = (cnt_reg >= apm_pkg::CNT_W'(RECOVERY_CYCLES));
  wire read_now = (state_reg == apm_pkg::APH_BUSY) && !busy_reg && !shutdown_req;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      apm_pkg::APH_WAIT: begin
        cnt_next = '0;
        if (shutdown_req) begin
          state_next = apm_pkg::APH_SHUT;
        end else if (convert_req) begin
          state_next = apm_pkg::APH_HIGH;
        end
      end
      apm_pkg::APH_HIGH: begin
        // (R4) Start held high past 200ns, margin for sync
        cnt_next = cnt_reg + 1'b1;
        if (high_done) begin
          state_next = apm_pkg::APH_LOW;
          cnt_next = '0;
        end
      end
      apm_pkg::APH_LOW: begin
        // Wait for busy to show through the synchroniser
        cnt_next = cnt_reg + 1'b1;
        if (busy_reg) begin
          state_next = apm_pkg::APH_BUSY;
        end
      end
      apm_pkg::APH_BUSY: begin
        if (!busy_reg) begin
          state_next = shutdown_req ? apm_pkg::APH_SHUT : apm_pkg::APH_WAIT;
        end
      end
      apm_pkg::APH_SHUT: begin
        cnt_next = '0;
        if (!shutdown_req) begin
          state_next = apm_pkg::APH_RECOVER;
        end
      end
      apm_pkg::APH_RECOVER: begin
        // (R12) Recovery wait before next conversion
        cnt_next = cnt_reg + 1'b1;
        if (rec_done) begin
          state_next = apm_pkg::APH_WAIT;
        end
      end
      default: begin
        state_next = apm_pkg::APH_WAIT;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= apm_pkg::APH_WAIT;
      cnt_reg <= '0;
      start_n_reg <= 1'b0;
      pd_reg <= 1'b0;
      data_reg <= apm_pkg::RESULT_RESET;
      valid_reg <= 1'b0;
      pending_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // (R3) Start kept low between conversions for nap
      start_n_reg <= (state_next == apm_pkg::APH_HIGH);
      // (R9) Power-down raised on entry to APH_SHUT; a pending result is read after release
      pd_reg <= (state_next == apm_pkg::APH_SHUT);
      valid_reg <= 1'b0;
      if (state_reg == apm_pkg::APH_BUSY && !busy_reg && shutdown_req) begin
        pending_reg <= 1'b1;
      end
      // (R8) Deferred read once shutdown released
      if (read_now || (pending_reg && state_reg == apm_pkg::APH_RECOVER && cnt_reg == '0)) begin
        data_reg <= link.result;
        valid_reg <= 1'b1;
        pending_reg <= 1'b0;
      end
    end
  end

  assign link.conversion_start_n = start_n_reg;
  assign link.power_down_request = pd_reg;
  assign convert_ready = (state_reg == apm_pkg::APH_WAIT) && !shutdown_req;
  assign sample_data = data_reg;
  assign sample_valid = valid_reg;
  assign in_shutdown = (state_reg == apm_pkg::APH_SHUT);
endmodule

// File: tb/apm_props.sv
// Checker for the link between converter and host ends.
// Assumes the link signals and a synchronous active-high reset.
`timescale 1ns/1ps
module apm_props #(
  parameter int unsigned CONV_CYCLES = apm_pkg::CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic conversion_start_n,
  input wire logic power_down_request,
  input wire logic busy,
  input wire logic [apm_pkg::RESULT_W-1:0] result
);
  // Counter, since busy is too long for a repetition
  logic [7:0] busy_cnt_reg;
  wire [7:0] busy_cnt_next = busy ? busy_cnt_reg + 8'h01 : 8'h00;
  always_ff @(posedge core_clk) begin
    busy_cnt_reg <= reset ? 8'h00 : busy_cnt_next;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_start;
    $fell(conversion_start_n) && !power_down_request && !busy;
  endsequence
  sequence s_done;
    $fell(busy);
  endsequence
  property p_start_busy; s_start |-> ##[3:8] busy; endproperty
  property p_busy_len; s_done |-> busy_cnt_reg == CONV_CYCLES; endproperty
  property p_shut_quiet; power_down_request && !busy |=> !busy; endproperty
  property p_result_at_end; !$stable(result) |-> s_done; endproperty
  property p_result_hold; power_down_request && !busy |=> $stable(result); endproperty
  property p_nap_exit; $rose(conversion_start_n) |-> conversion_start_n [*8]; endproperty
  property p_start_idle; $fell(conversion_start_n) |-> !busy; endproperty
  property p_recover; $fell(power_down_request) |-> (!$fell(conversion_start_n)) [*8]; endproperty
  a_start_busy: assert property (p_start_busy)
    else $error("busy did not follow start");
  a_busy_len: assert property (p_busy_len)
    else $error("conversion length wrong");
  a_shut_quiet: assert property (p_shut_quiet)
    else $error("conversion in shutdown");
  a_result_at_end: assert property (p_result_at_end)
    else $error("result changed outside conversion end");
  a_result_hold: assert property (p_result_hold)
    else $error("result changed in shutdown");
  a_nap_exit: assert property (p_nap_exit)
    else $error("start high too short");
  a_start_idle: assert property (p_start_idle)
    else $error("start during conversion");
  a_recover: assert property (p_recover)
    else $error("start too soon after shutdown");
endmodule

// File: tb/adc_power_mode_control_bench.sv
// Bench joining converter and host ends through the link.
// Assumes the host recovery wait is shortened to 50 cycles.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("MISMATCH %0t value differs", $time); end end
module adc_power_mode_control_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] supply_mv = 16'h1388;
  logic [15:0] sample_in = 16'h0000;
  logic convert_req = 1'b0;
  logic shutdown_req = 1'b0;
  logic reference_on, napping, shutdown, convert_ready, sample_valid, in_shutdown, got;
  logic [15:0] sample_data;
  logic [15:0] rows [4] = '{16'h0000, 16'hffff, 16'ha5c3, 16'h8001};
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  apm_if link();
  apm_device u_apm_device (.core_clk(core_clk), .reset(reset), .supply_mv(supply_mv),
    .sample_in(sample_in), .link(link), .reference_on(reference_on), .napping(napping),
    .shutdown(shutdown));
  apm_host #(.RECOVERY_CYCLES(50)) u_apm_host (.core_clk(core_clk), .reset(reset),
    .convert_req(convert_req), .shutdown_req(shutdown_req), .convert_ready(convert_ready),
    .sample_data(sample_data), .sample_valid(sample_valid), .in_shutdown(in_shutdown),
    .link(link));
  // Supply dip resets the converter, so the checker stands down with it
  apm_props u_apm_props (.core_clk(core_clk), .reset(reset || (supply_mv < apm_pkg::SUPPLY_MIN_MV)),
    .conversion_start_n(link.conversion_start_n), .power_down_request(link.power_down_request),
    .busy(link.busy), .result(link.result));
  always #12.5 core_clk = ~core_clk;
  task test_done;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Ceiling well above the expected few hundred cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  task start_conv(input logic [15:0] v);
    for (int i = 0; i < 400 && convert_ready !== 1'b1; i++) @(negedge core_clk);
    sample_in = v;
    convert_req = 1'b1;
    @(negedge core_clk);
    convert_req = 1'b0;
  endtask
  task get_result(input logic [15:0] v);
    for (int i = 0; i < 400 && sample_valid !== 1'b1; i++) @(negedge core_clk);
    `CHK(sample_valid, 1'b1)
    `CHK(sample_data, v)
  endtask
  initial begin
    repeat (12) @(negedge core_clk);
    `CHK(reference_on, 1'b0)
    `CHK(link.result, 16'h0000)
    reset = 1'b0;
    foreach (rows[k]) begin
      start_conv(rows[k]);
      get_result(rows[k]);
      repeat (2) @(negedge core_clk);
      `CHK(napping, 1'b1)
      `CHK(link.busy, 1'b0)
    end
    // Supply dip: threshold itself is still nominal
    supply_mv = 16'h09c3;
    repeat (3) @(negedge core_clk);
    `CHK(reference_on, 1'b0)
    `CHK(link.result, 16'h0000)
    supply_mv = 16'h09c4;
    repeat (3) @(negedge core_clk);
    `CHK(reference_on, 1'b1)
    start_conv(16'h1234);
    get_result(16'h1234);
    shutdown_req = 1'b1;
    repeat (12) @(negedge core_clk);
    `CHK(shutdown, 1'b1)
    `CHK(reference_on, 1'b0)
    `CHK(link.busy, 1'b0)
    `CHK(convert_ready, 1'b0)
    shutdown_req = 1'b0;
    repeat (40) @(negedge core_clk);
    `CHK(convert_ready, 1'b0)
    `CHK(reference_on, 1'b1)
    // Shutdown requested mid-conversion
    start_conv(16'h3c5a);
    for (int i = 0; i < 100 && link.busy !== 1'b1; i++) @(negedge core_clk);
    shutdown_req = 1'b1;
    got = 1'b0;
    repeat (30) begin
      @(negedge core_clk);
      if (sample_valid === 1'b1) got = 1'b1;
    end
    `CHK(got, 1'b0)
    `CHK(link.result, 16'h3c5a)
    `CHK(shutdown, 1'b1)
    shutdown_req = 1'b0;
    get_result(16'h3c5a);
    start_conv(16'h7e01);
    get_result(16'h7e01);
    test_done();
  end
endmodule
